// ### e1_tx_pkg.sv
// Shared constants for the E1 transmit packet link: register offsets,
// field positions, reset values, framing patterns and engine states.
// Assumes an 8-bit CPU register port and one 250 MHz core clock.
package e1_tx_pkg;
   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFF_LINK_SELECT = 8'h0A;
   localparam logic [7:0] OFF_LINK_ONE_POSITION = 8'h28;
   localparam logic [7:0] OFF_LINK_ONE_BIT_MASK = 8'h29;
   localparam logic [7:0] OFF_LINK_TWO_POSITION = 8'h2A;
   localparam logic [7:0] OFF_LINK_TWO_BIT_MASK = 8'h2B;
   localparam logic [7:0] OFF_LINK_THREE_POSITION = 8'h2C;
   localparam logic [7:0] OFF_LINK_THREE_BIT_MASK = 8'h2D;
   localparam logic [7:0] OFF_TX_CONTROL = 8'h50;
   localparam logic [7:0] OFF_UPPER_THRESHOLD = 8'h51;
   localparam logic [7:0] OFF_LOWER_THRESHOLD = 8'h52;
   localparam logic [7:0] OFF_IRQ_ENABLE = 8'h53;
   localparam logic [7:0] OFF_TX_STATUS = 8'h54;
   localparam logic [7:0] OFF_TX_DATA = 8'h55;
   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int SEL_PATH_BIT = 3;
   localparam int SEL_LINK_LSB = 4;
   localparam int POS_EVEN_BIT = 7;
   localparam int POS_ODD_BIT = 6;
   localparam int POS_TS16_BIT = 5;
   localparam int CTL_ENABLE_BIT = 0;
   localparam int CTL_CRC_BIT = 1;
   localparam int CTL_EOM_BIT = 3;
   localparam int CTL_CLEAR_BIT = 6;
   localparam int ST_FULL_BIT = 3;
   localparam int ST_OVERRUN_BIT = 2;
   localparam int ST_UNDERRUN_BIT = 1;
   localparam int ST_LOW_FILL_BIT = 0;
   // ---------------------------------------------------------------
   // Reset values and framing constants
   // ---------------------------------------------------------------
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_UPPER_THRESHOLD = 8'h06;
   localparam logic [7:0] RST_LOWER_THRESHOLD = 8'h02;
   localparam logic [4:0] SLOT_SIXTEEN = 5'h10;
   localparam logic [7:0] HDLC_FLAG = 8'h7E;
   localparam logic [7:0] HDLC_ABORT = 8'hFF;
   localparam logic [15:0] CRC_INIT = 16'hFFFF;
   localparam logic [15:0] CRC_POLY_REFL = 16'h8408;
   localparam logic [2:0] ONES_BEFORE_STUFF = 3'h5;
   localparam logic [1:0] LINK_NONE = 2'h3;

   typedef enum logic [1:0] {ST_IDLE, ST_DATA, ST_FCS} tx_state_t;
endpackage

// ### tx_byte_fifo.sv
// Byte FIFO between the CPU data register and the HDLC serializer.
// Assumes one clock; a clear level empties it and holds it empty.
module tx_byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic i_clear,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data,
   output logic [$clog2(DEPTH):0] o_level
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW:0] count_r;
   wire push = i_in_valid && o_in_ready;
   wire pop = o_out_valid && i_out_ready;
   wire [AW-1:0] wr_ptr_inc = (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
   wire [AW-1:0] rd_ptr_inc = (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;

   assign o_in_ready = !i_clear && (count_r != (AW + 1)'(DEPTH));
   assign o_out_valid = !i_clear && (count_r != '0);
   assign o_out_data = mem_r[rd_ptr_r];
   assign o_level = count_r;

   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end
      else if (i_clear)
      begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end
      else
      begin
         if (push)
            wr_ptr_r <= wr_ptr_inc;
         if (pop)
            rd_ptr_r <= rd_ptr_inc;
         count_r <= count_r + (AW + 1)'(push) - (AW + 1)'(pop);
      end
   end

   always_ff @(posedge i_core_clk)
   begin
      if (push)
         mem_r[wr_ptr_r] <= i_in_data;
   end
endmodule

// ### e1_hdlc_transmit_link.sv
// Transmit HDLC link inserter for one E1 framer: CPU registers, a byte
// FIFO and a bit-serial HDLC engine placing bits into chosen E1 positions.
// Assumes the framer gives one strobe per E1 bit with slot, bit and frame parity.
module e1_hdlc_transmit_link #(
   parameter int FIFO_DEPTH = 8
) (
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic [7:0] i_cpu_addr,
   input wire logic i_cpu_wr,
   input wire logic i_cpu_rd,
   input wire logic [7:0] i_cpu_wdata,
   output logic [7:0] o_cpu_rdata,
   output logic o_tx_fifo_ready,
   input wire logic i_bit_strobe,
   input wire logic [4:0] i_slot_num,
   input wire logic [2:0] i_bit_num,
   input wire logic i_odd_frame,
   output logic o_tx_bit,
   output logic o_tx_bit_valid,
   output logic [1:0] o_tx_link,
   output logic o_int_n
);
   import e1_tx_pkg::*;
   localparam int LW = $clog2(FIFO_DEPTH) + 1;

   // ---------------------------------------------------------------
   // Register file
   // ---------------------------------------------------------------
   logic [7:0] link_sel_r;
   logic [7:0] pos_r [3];
   logic [7:0] mask_r [3];
   logic [7:0] ctrl_r;
   logic [7:0] upper_thr_r;
   logic [7:0] lower_thr_r;
   logic [7:0] irq_en_r;
   logic overrun_r;
   logic underrun_r;
   logic eom_pending_r;

   wire wr_sel = i_cpu_wr && (i_cpu_addr == OFF_LINK_SELECT);
   wire wr_ctrl = i_cpu_wr && (i_cpu_addr == OFF_TX_CONTROL);
   wire wr_upper = i_cpu_wr && (i_cpu_addr == OFF_UPPER_THRESHOLD);
   wire wr_lower = i_cpu_wr && (i_cpu_addr == OFF_LOWER_THRESHOLD);
   wire wr_irq_en = i_cpu_wr && (i_cpu_addr == OFF_IRQ_ENABLE);
   wire wr_data = i_cpu_wr && (i_cpu_addr == OFF_TX_DATA);
   wire rd_status = i_cpu_rd && (i_cpu_addr == OFF_TX_STATUS);
   // transmit path gate
   // Position writes with the path bit low belong to the receive side
   wire pos_path_tx = link_sel_r[SEL_PATH_BIT];
   wire pos_area = (i_cpu_addr >= OFF_LINK_ONE_POSITION) && (i_cpu_addr <= OFF_LINK_THREE_BIT_MASK);
   wire [7:0] pos_ofs = i_cpu_addr - OFF_LINK_ONE_POSITION;
   wire [1:0] pos_idx = pos_ofs[2:1];
   wire wr_pos = i_cpu_wr && pos_area && pos_path_tx && !pos_ofs[0];
   wire wr_mask = i_cpu_wr && pos_area && pos_path_tx && pos_ofs[0];

   // ---------------------------------------------------------------
   // FIFO
   // ---------------------------------------------------------------
   wire fifo_clear = ctrl_r[CTL_CLEAR_BIT];
   wire fifo_in_ready;
   wire fifo_out_valid;
   wire fifo_pop;
   wire [7:0] fifo_out_data;
   wire [LW-1:0] fifo_level;
   wire [7:0] level8 = 8'(fifo_level);

   tx_byte_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .i_core_clk(i_core_clk),
      .i_rst_n(i_rst_n),
      .i_clear(fifo_clear),
      .i_in_valid(wr_data),
      .o_in_ready(fifo_in_ready),
      .i_in_data(i_cpu_wdata),
      .o_out_valid(fifo_out_valid),
      .i_out_ready(fifo_pop),
      .o_out_data(fifo_out_data),
      .o_level(fifo_level)
   );
   assign o_tx_fifo_ready = fifo_in_ready;

   // ---------------------------------------------------------------
   // Status and interrupt
   // ---------------------------------------------------------------
   // threshold compares
   wire fill_at_upper = (level8 >= upper_thr_r);
   wire fifo_full = !fifo_in_ready && !fifo_clear;
   wire below_low_fill_flag = (level8 < lower_thr_r);
   wire overrun_set = wr_data && !fifo_in_ready;
   wire underrun_set;
   wire [7:0] status = {4'h0, fifo_full, overrun_r, underrun_r, below_low_fill_flag};
   wire irq_any = |(irq_en_r[3:0] & status[3:0]);

   // ---------------------------------------------------------------
   // Position match for the selected link
   // ---------------------------------------------------------------
   // selector picks link
   wire [1:0] tx_link_selector = link_sel_r[SEL_LINK_LSB +: 2];
   wire link_ok = (tx_link_selector != LINK_NONE);
   wire [1:0] link_idx = link_ok ? tx_link_selector : 2'h0;
   wire [7:0] cur_pos = pos_r[link_idx];
   wire [7:0] cur_mask = mask_r[link_idx];
   wire slot_sixteen_enable = cur_pos[POS_TS16_BIT];
   wire parity_ok = i_odd_frame ? cur_pos[POS_ODD_BIT] : cur_pos[POS_EVEN_BIT];
   wire [2:0] mask_idx = 3'h7 - i_bit_num;
   // frame parity, chosen slot, bit mask
   wire pos_match = slot_sixteen_enable ? (i_slot_num == SLOT_SIXTEEN)
      : (parity_ok && (i_slot_num == cur_pos[4:0]) && cur_mask[mask_idx]);
   wire link_on = ctrl_r[CTL_ENABLE_BIT] && link_ok && !fifo_clear;
   wire bit_tick = i_bit_strobe && link_on && pos_match;

   // ---------------------------------------------------------------
   // HDLC engine
   // ---------------------------------------------------------------
   tx_state_t state_r;
   tx_state_t state_nxt;
   logic [7:0] shift_r;
   logic [7:0] shift_nxt;
   logic [2:0] bcnt_r;
   logic [2:0] ones_r;
   logic [2:0] ones_nxt;
   logic [15:0] crc_r;
   logic [15:0] crc_nxt;
   logic [7:0] fcs_hi_r;
   logic fcs_second_r;
   logic fcs_second_nxt;
   logic out_bit;
   logic pop_req;
   logic underrun_hit;
   logic eom_done;

   wire framed = (state_r != ST_IDLE);
   // stuff a zero after five ones
   // Ones count only while framed, so a five-ones tail still gets its zero
   wire stuff_now = (ones_r == ONES_BEFORE_STUFF);
   wire byte_end = !stuff_now && (bcnt_r == 3'h7);
   wire start_ok = fifo_out_valid && (eom_pending_r || fill_at_upper);
   wire crc_fb = crc_r[0] ^ shift_r[0];
   wire [15:0] crc_step = {1'b0, crc_r[15:1]} ^ (crc_fb ? CRC_POLY_REFL : 16'h0000);

   assign fifo_pop = bit_tick && pop_req;
   assign underrun_set = bit_tick && underrun_hit;

   always_comb
   begin
      state_nxt = state_r;
      shift_nxt = {1'b0, shift_r[7:1]};
      ones_nxt = ones_r;
      crc_nxt = crc_r;
      fcs_second_nxt = fcs_second_r;
      out_bit = shift_r[0];
      pop_req = 1'b0;
      underrun_hit = 1'b0;
      eom_done = 1'b0;
      if (stuff_now)
      begin
         out_bit = 1'b0;
         shift_nxt = shift_r;
         ones_nxt = 3'h0;
      end
      else
      begin
         if (framed)
            ones_nxt = shift_r[0] ? ones_r + 3'h1 : 3'h0;
         if (state_r == ST_DATA)
            crc_nxt = crc_step;
      end
      if (byte_end)
      begin
         case (state_r)
            ST_IDLE:
            begin
               // Run of ones carries across data bytes; only idle flag and abort bytes restart it
               ones_nxt = 3'h0;
               shift_nxt = HDLC_FLAG;
               if (start_ok)
               begin
                  shift_nxt = fifo_out_data;
                  pop_req = 1'b1;
                  crc_nxt = CRC_INIT;
                  state_nxt = ST_DATA;
               end
            end
            ST_DATA:
            begin
               if (fifo_out_valid)
               begin
                  shift_nxt = fifo_out_data;
                  pop_req = 1'b1;
               end
               // append check sequence only when enabled
               else if (eom_pending_r && ctrl_r[CTL_CRC_BIT])
               begin
                  shift_nxt = ~crc_step[7:0];
                  fcs_second_nxt = 1'b0;
                  state_nxt = ST_FCS;
               end
               else if (eom_pending_r)
               begin
                  shift_nxt = HDLC_FLAG;
                  eom_done = 1'b1;
                  state_nxt = ST_IDLE;
               end
               else
               begin
                  // Starved mid-packet: abort with ones, then flags
                  shift_nxt = HDLC_ABORT;
                  underrun_hit = 1'b1;
                  state_nxt = ST_IDLE;
               end
            end
            ST_FCS:
            begin
               if (!fcs_second_r)
               begin
                  shift_nxt = fcs_hi_r;
                  fcs_second_nxt = 1'b1;
               end
               else
               begin
                  shift_nxt = HDLC_FLAG;
                  eom_done = 1'b1;
                  state_nxt = ST_IDLE;
               end
            end
            default:
            begin
               shift_nxt = HDLC_FLAG;
               state_nxt = ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         state_r <= ST_IDLE;
         shift_r <= HDLC_FLAG;
         bcnt_r <= 3'h0;
         ones_r <= 3'h0;
         crc_r <= CRC_INIT;
         fcs_hi_r <= RST_ZERO;
         fcs_second_r <= 1'b0;
      end
      else if (!link_on)
      begin
         state_r <= ST_IDLE;
         shift_r <= HDLC_FLAG;
         bcnt_r <= 3'h0;
         ones_r <= 3'h0;
      end
      else if (bit_tick)
      begin
         state_r <= state_nxt;
         shift_r <= shift_nxt;
         ones_r <= ones_nxt;
         crc_r <= crc_nxt;
         fcs_second_r <= fcs_second_nxt;
         if (!stuff_now)
            bcnt_r <= bcnt_r + 3'h1;
         if (state_r == ST_DATA && byte_end)
            fcs_hi_r <= ~crc_step[15:8];
      end
   end

   // ---------------------------------------------------------------
   // Register writes, sticky flags, outputs
   // ---------------------------------------------------------------
   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         link_sel_r <= RST_ZERO;
         pos_r <= '{RST_ZERO, RST_ZERO, RST_ZERO};
         mask_r <= '{RST_ZERO, RST_ZERO, RST_ZERO};
         ctrl_r <= RST_ZERO;
         upper_thr_r <= RST_UPPER_THRESHOLD;
         lower_thr_r <= RST_LOWER_THRESHOLD;
         irq_en_r <= RST_ZERO;
         overrun_r <= 1'b0;
         underrun_r <= 1'b0;
         eom_pending_r <= 1'b0;
         o_cpu_rdata <= RST_ZERO;
         o_tx_bit <= 1'b1;
         o_tx_bit_valid <= 1'b0;
         o_tx_link <= 2'h0;
         o_int_n <= 1'b1;
      end
      else
      begin
         if (wr_sel)
            link_sel_r <= i_cpu_wdata;
         if (wr_pos)
            pos_r[pos_idx] <= i_cpu_wdata;
         if (wr_mask)
            mask_r[pos_idx] <= i_cpu_wdata;
         // clear bit held as a level
         if (wr_ctrl)
            ctrl_r <= i_cpu_wdata & 8'hF7;
         if (wr_upper)
            upper_thr_r <= i_cpu_wdata;
         if (wr_lower)
            lower_thr_r <= i_cpu_wdata;
         if (wr_irq_en)
            irq_en_r <= i_cpu_wdata & 8'h0F;
         // Set wins over the read-clear
         overrun_r <= overrun_set || (overrun_r && !rd_status);
         underrun_r <= underrun_set || (underrun_r && !rd_status);
         // End-of-message is a strobe; the mark waits for the packet's end
         if (wr_ctrl && i_cpu_wdata[CTL_EOM_BIT])
            eom_pending_r <= 1'b1;
         else if ((bit_tick && eom_done) || fifo_clear)
            eom_pending_r <= 1'b0;
         o_cpu_rdata <= rd_data_mux();
         o_tx_bit_valid <= bit_tick;
         if (bit_tick)
            o_tx_bit <= out_bit;
         o_tx_link <= link_idx;
         o_int_n <= !irq_any;
      end
   end

   function automatic logic [7:0] rd_data_mux();
      logic [7:0] v;
      v = RST_ZERO;
      if (i_cpu_addr == OFF_LINK_SELECT)
         v = link_sel_r;
      else if (pos_area && !pos_ofs[0] && pos_idx != 2'h3)
         v = pos_r[pos_idx];
      else if (pos_area && pos_ofs[0] && pos_idx != 2'h3)
         v = mask_r[pos_idx];
      else if (i_cpu_addr == OFF_TX_CONTROL)
         v = ctrl_r;
      else if (i_cpu_addr == OFF_UPPER_THRESHOLD)
         v = upper_thr_r;
      else if (i_cpu_addr == OFF_LOWER_THRESHOLD)
         v = lower_thr_r;
      else if (i_cpu_addr == OFF_IRQ_ENABLE)
         v = irq_en_r;
      else if (i_cpu_addr == OFF_TX_STATUS)
         v = status;
      return v;
   endfunction

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);

   sequence s_select_write;
      wr_sel && i_cpu_wdata == 8'h58;
   endsequence
   sequence s_link_two_chosen;
      tx_link_selector == 2'h1 && pos_path_tx;
   endsequence

   a_select_link_two: assert property (s_select_write |=> s_link_two_chosen)
      else $error("link select write of 58H did not pick link two");
   a_int_pin_follow: assert property (irq_any |=> !o_int_n)
      else $error("enabled condition did not drive interrupt low");
   a_disabled_quiet: assert property (!ctrl_r[CTL_ENABLE_BIT] |=> !o_tx_bit_valid)
      else $error("disabled link inserted a bit");
   a_slot16_only: assert property (i_bit_strobe && slot_sixteen_enable && i_slot_num != SLOT_SIXTEEN
      |=> !o_tx_bit_valid)
      else $error("slot-16 mode inserted outside slot 16");
   a_mask_insert: assert property (i_bit_strobe && link_on && !slot_sixteen_enable && parity_ok
      && i_slot_num == cur_pos[4:0] && cur_mask[mask_idx] |=> o_tx_bit_valid)
      else $error("matching position did not carry a link bit");
   a_clear_empties: assert property (fifo_clear |=> fifo_level == '0 && !fifo_out_valid)
      else $error("clear bit did not empty the FIFO");
   a_push_order: assert property (wr_data && fifo_in_ready && !fifo_pop
      |=> fifo_level == $past(fifo_level) + LW'(1))
      else $error("data write did not enter the FIFO");
   a_stuff_zero: assert property (bit_tick && stuff_now |=> !o_tx_bit && bcnt_r == $past(bcnt_r))
      else $error("zero not stuffed after five ones");
   a_start_send: assert property (bit_tick && state_r == ST_IDLE && byte_end && start_ok
      |=> state_r == ST_DATA)
      else $error("packet did not start");
   a_fcs_append: assert property (bit_tick && state_r == ST_DATA && byte_end && !fifo_out_valid
      && eom_pending_r |=> (state_r == ST_FCS) == $past(ctrl_r[CTL_CRC_BIT]))
      else $error("check sequence choice wrong at packet end");
endmodule

// ### host_model.sv
// Host processor model: byte writes and reads on the block's CPU port.
// Assumes the block takes a strobe on the rising edge of the core clock.
module host_model (
   input wire logic i_core_clk,
   input wire logic [7:0] i_cpu_rdata,
   output logic [7:0] o_cpu_addr,
   output logic o_cpu_wr,
   output logic o_cpu_rd,
   output logic [7:0] o_cpu_wdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      o_cpu_addr = 8'h00;
      o_cpu_wr = 1'h0;
      o_cpu_rd = 1'h0;
      o_cpu_wdata = 8'h00;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_core_clk);
      o_cpu_addr = a;
      o_cpu_wdata = d;
      o_cpu_wr = 1'h1;
      @(negedge i_core_clk);
      o_cpu_wr = 1'h0;
      // Released bus shows a changed byte, never the stale one
      o_cpu_wdata = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge i_core_clk);
      o_cpu_addr = a;
      o_cpu_rd = 1'h1;
      @(negedge i_core_clk);
      d = i_cpu_rdata;
      o_cpu_rd = 1'h0;
   endtask
endmodule

// ### e1_hdlc_transmit_link_bench.sv
// Bench for the E1 transmit packet link: registers, FIFO and framed output.
// Assumes the host model drives the CPU port and a counter stands in for the framer.
module e1_hdlc_transmit_link_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import e1_tx_pkg::*;
   logic core_clk = 1'h0;
   logic rst_n = 1'h0;
   logic run = 1'h0;
   logic bit_strobe = 1'h0;
   logic odd_frame = 1'h0;
   logic [7:0] pos = 8'h00;
   logic [7:0] cpu_addr, cpu_wdata, cpu_rdata, by, v;
   logic [7:0] win = 8'h00;
   logic cpu_wr, cpu_rd, fifo_ready, tx_bit, tx_bit_valid, int_n;
   logic [1:0] tx_link;
   logic acc[$];
   logic [7:0] rx[$], exp_q[$];
   int failures = 0, n_compared = 0, valids = 0, ones = 0, n;
   // ---------------------------------------------------------------
   // Design, host and framer timing
   // ---------------------------------------------------------------
   always #2 core_clk = ~core_clk;
   always @(negedge core_clk)
   begin
      bit_strobe <= run;
      pos <= pos + 8'h01;
      if (pos == 8'hFF)
         odd_frame <= ~odd_frame;
   end
   host_model host_model_inst (.i_core_clk(core_clk), .i_cpu_rdata(cpu_rdata), .o_cpu_addr(cpu_addr),
      .o_cpu_wr(cpu_wr), .o_cpu_rd(cpu_rd), .o_cpu_wdata(cpu_wdata));
   e1_hdlc_transmit_link #(.FIFO_DEPTH(8)) e1_hdlc_transmit_link_inst (.i_core_clk(core_clk), .i_rst_n(rst_n),
      .i_cpu_addr(cpu_addr), .i_cpu_wr(cpu_wr), .i_cpu_rd(cpu_rd), .i_cpu_wdata(cpu_wdata),
      .o_cpu_rdata(cpu_rdata), .o_tx_fifo_ready(fifo_ready), .i_bit_strobe(bit_strobe),
      .i_slot_num(pos[7:3]), .i_bit_num(pos[2:0]), .i_odd_frame(odd_frame), .o_tx_bit(tx_bit),
      .o_tx_bit_valid(tx_bit_valid), .o_tx_link(tx_link), .o_int_n(int_n));
   // ---------------------------------------------------------------
   // Link decoder: flags delimit, stuffed zeros dropped
   // ---------------------------------------------------------------
   always @(negedge core_clk)
   if (tx_bit_valid === 1'h1)
   begin
      valids++;
      win = {tx_bit, win[7:1]};
      if (win == HDLC_FLAG)
      begin
         for (int i = 0; i + 15 <= acc.size(); i += 8)
         begin
            for (int k = 0; k < 8; k++)
               by[k] = acc[i+k];
            rx.push_back(by);
         end
         acc.delete();
         ones = 0;
      end
      else if (tx_bit == 1'h0 && ones == 5)
         ones = 0;
      else
      begin
         acc.push_back(tx_bit);
         ones = tx_bit ? ones + 1 : 0;
      end
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] want, input string what);
      n_compared++;
      if (seen !== want)
      begin
         failures++;
         $display("MISMATCH at %0t: %s seen %h want %h", $time, what, seen, want);
      end
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] want);
      logic [7:0] d;
      host_model_inst.rd(a, d);
      check(d, want, "register read");
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      host_model_inst.wr(a, d);
   endtask
   function automatic logic [15:0] fcs(input logic [7:0] q[$]);
      logic [15:0] c = CRC_INIT;
      foreach (q[i])
         for (int k = 0; k < 8; k++)
            c = (c[0] ^ q[i][k]) ? (c >> 1) ^ CRC_POLY_REFL : c >> 1;
      return ~c;
   endfunction
   task automatic expect_frame(input logic crc_on);
      logic [15:0] c;
      c = fcs(exp_q);
      if (crc_on)
      begin
         exp_q.push_back(c[7:0]);
         exp_q.push_back(c[15:8]);
      end
      run = 1'h1;
      for (int i = 0; i < 30000 && rx.size() < exp_q.size(); i++)
         @(posedge core_clk);
      run = 1'h0;
      check(8'(rx.size()), 8'(exp_q.size()), "frame length"); // whole frame
      foreach (exp_q[i])
         check(rx[i], exp_q[i], "frame byte"); // byte order
      rx.delete();
      exp_q.delete();
   endtask
   task automatic give_verdict();
      $display("compared %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial
   begin
      #200000;
      failures++;
      $display("MISMATCH at %0t: watchdog expired", $time);
      give_verdict();
   end
   initial
   begin
      void'($urandom(76));
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      rst_n = 1'h1;
      rc(OFF_UPPER_THRESHOLD, RST_UPPER_THRESHOLD); // upper
      rc(OFF_LOWER_THRESHOLD, RST_LOWER_THRESHOLD); // lower
      rc(OFF_TX_STATUS, 8'h01); // low fill
      rc(8'h7F, 8'h00);
      check({7'h00, int_n}, 8'h01, "interrupt idle"); // masked
      $display("test reset done");
      wr(OFF_UPPER_THRESHOLD, 8'hFF);
      wr(OFF_LINK_SELECT, 8'h58);
      wr(OFF_LINK_TWO_POSITION, 8'hC4);
      wr(OFF_LINK_TWO_BIT_MASK, 8'hFF);
      wr(OFF_LINK_SELECT, 8'h10);
      wr(OFF_LINK_TWO_POSITION, 8'h00);
      wr(OFF_LINK_SELECT, 8'h58);
      rc(OFF_LINK_TWO_POSITION, 8'hC4); // kept
      check({6'h00, tx_link}, 8'h01, "link index"); // link two
      run = 1'h1;
      repeat (600) @(posedge core_clk);
      run = 1'h0;
      check(8'(valids), 8'h00, "idle while disabled"); // enable
      $display("test select done");
      wr(OFF_TX_CONTROL, 8'hC3);
      wr(OFF_TX_CONTROL, 8'h83);
      wr(OFF_IRQ_ENABLE, 8'h0F);
      rc(OFF_IRQ_ENABLE, 8'h0F); // enables
      exp_q = '{8'h12, 8'h34, 8'h56, 8'h78, 8'h9A, 8'hBC, 8'hDE, 8'hFF};
      foreach (exp_q[i])
         wr(OFF_TX_DATA, exp_q[i]);
      check({7'h00, fifo_ready}, 8'h00, "ready when full"); // full
      rc(OFF_TX_STATUS, 8'h08); // full flag, source read first
      check({7'h00, int_n}, 8'h00, "full interrupt"); // full
      wr(OFF_TX_DATA, 8'hAA);
      rc(OFF_TX_STATUS, 8'h0C); // overrun
      rc(OFF_TX_STATUS, 8'h08); // read clears
      wr(OFF_TX_CONTROL, 8'h8B);
      expect_frame(1'h1); // with check sequence
      rc(OFF_TX_STATUS, 8'h01); // low fill
      check({7'h00, int_n}, 8'h00, "low fill interrupt"); // low fill
      $display("test packet done");
      wr(OFF_TX_CONTROL, 8'h00);
      wr(OFF_TX_DATA, 8'hEE);
      wr(OFF_LINK_SELECT, 8'h68);
      wr(OFF_LINK_THREE_POSITION, 8'hD4);
      wr(OFF_LINK_THREE_BIT_MASK, 8'hFF);
      wr(OFF_TX_CONTROL, 8'h41);
      wr(OFF_TX_CONTROL, 8'h01);
      exp_q.push_back(HDLC_FLAG);
      n = 1 + $urandom % 5;
      repeat (n) exp_q.push_back(8'($urandom));
      foreach (exp_q[i])
         wr(OFF_TX_DATA, exp_q[i]);
      wr(OFF_TX_CONTROL, 8'h09);
      expect_frame(1'h0); // slot twenty, no check sequence
      check({6'h00, tx_link}, 8'h02, "link index"); // link three
      $display("test random done");
      wr(OFF_IRQ_ENABLE, 8'h00);
      wr(OFF_LINK_SELECT, 8'h08);
      wr(OFF_LINK_ONE_POSITION, 8'h40);
      wr(OFF_LINK_ONE_BIT_MASK, 8'h1F);
      wr(OFF_UPPER_THRESHOLD, 8'h02);
      run = 1'h1;
      wr(OFF_TX_DATA, 8'($urandom));
      wr(OFF_TX_DATA, 8'h3C);
      repeat (8000) @(posedge core_clk);
      host_model_inst.rd(OFF_TX_STATUS, v);
      check(v & 8'h02, 8'h02, "underrun after threshold start"); // threshold start
      check({7'h00, int_n}, 8'h01, "no interrupt when polling"); // masked
      check({6'h00, tx_link}, 8'h00, "link index"); // link one
      $display("test threshold done");
      give_verdict();
   end
endmodule
